// [src/pid_regulator_consts.vh]
// Constants for the process-loop regulator: scalings, defaults, codes.
// Assumes a 50 MHz core clock; included by the regulator module only.
`ifndef PID_REGULATOR_CONSTS_VH
`define PID_REGULATOR_CONSTS_VH

// Core clock rate in Hz and the control sample period in microseconds
`define CLK_HZ 50000000
`define SAMPLE_US 1000
// Cycles per control sample, derived from the rate (rounded down)
`define SAMPLE_CYC ((`CLK_HZ / 1000000) * `SAMPLE_US)

// Percent settings are in 0.1 % units: 1000 means 100.0 %
`define PCT_FULL 16'h03e8
// Error and output scale: 16'h4000 is 100 % of full scale
`define FS_VAL 16'h4000
// Frequencies in 0.01 Hz units
`define FREQ_60HZ 16'h1770
`define FREQ_0HZ 16'h0000
// Integral time in 0.1 s units: 100 means 10.0 s
`define ITIME_DEF 16'h0064
// Samples per 0.1 s of integral time
`define SAMPLES_PER_TENTH 16'h0064
// Derivative time default, milliseconds times ten
`define DTIME_DEF 16'h0000
// Sensorless speed loop gain defaults
`define SL_PGAIN_DEF 16'h03e8
`define SL_IGAIN_DEF 16'h0064

// Feedback source codes
`define FB_CURRENT 2'h0
`define FB_VMAIN 2'h1
`define FB_VEXP 2'h2

// Ramp reference modes and time resolution codes
`define RAMP_REF_MAX 1'h0
`define RAMP_REF_DELTA 1'h1
`define RES_10MS 2'h0
`define RES_100MS 2'h1
`define RES_1S 2'h2
// Largest ramp setting per resolution: 600 s, 6000 s, 60000 s
`define RAMP_MAX_10MS 17'h0ea60
`define RAMP_MAX_100MS 17'h0ea60
`define RAMP_MAX_1S 17'h0ea60

`endif

// [src/pid_regulator.v]
// Process-loop regulator with feed-forward, limits and ramp selection.
// Assumes settings and analog samples are synchronous to core_clk and
// already scaled so that 16'h4000 is full scale of the analog inputs.
`timescale 1ns/1ns
`include "pid_regulator_consts.vh"

// How it works
// - Gain 100 %, no integral: output equals error
// - Proportional term scales linearly with gain
// - Integral time is ramp time to full scale
// - Clamp commanded frequency at upper limit
// - Clamp commanded frequency at lower limit
// - Regulator output added to target frequency
// - Optional negation of regulator output
// - Regulator output multiplied by scale percentage
// - One scale applies to both proportional gains
// - Bypass input forces regulator output zero
// - Integrator-clear input zeroes the integral sum
// - Bypass selects the secondary proportional gain
// - Manual while bypass on, loop resumes after
// - Feedback from current, main or expansion input
// - Feed-forward passes gain percent of reference
// - Mode 0: ramp time spans zero to max
// - Mode 1: ramp time spans present to target
// - Resolution code picks 0.01, 0.1, 1 s steps
// - Change-over frequency switches between two ramps
// - Multi-step ramp inputs override change-over frequency
// - Speed loop proportional gain, default 1000
// - Speed loop integral gain, default 100
module pid_regulator #(
  parameter SAMPLE_CYCLES = `SAMPLE_CYC,
  parameter [15:0] SL_PGAIN_DEFAULT = `SL_PGAIN_DEF,
  parameter [15:0] SL_IGAIN_DEFAULT = `SL_IGAIN_DEF
) (
  input wire core_clk,
  input wire sys_rst,
  input wire regulation_enable,
  input wire [15:0] set_point,
  input wire [15:0] current_input,
  input wire [15:0] voltage_input_main,
  input wire [15:0] voltage_input_expansion,
  input wire [1:0] feedback_select,
  input wire [15:0] prop_gain,
  input wire [15:0] secondary_prop_gain,
  input wire [15:0] prop_gain_scale,
  input wire [15:0] integral_time,
  input wire [15:0] derivative_time,
  input wire [15:0] feed_forward_gain,
  input wire [15:0] output_scale_factor,
  input wire output_negate_option,
  input wire [15:0] output_freq_upper_limit,
  input wire [15:0] output_freq_lower_limit,
  input wire [15:0] target_freq,
  input wire [15:0] max_freq,
  input wire [15:0] present_freq,
  input wire manual_bypass_input,
  input wire integrator_clear_input,
  input wire ramp_ref_mode,
  input wire [1:0] ramp_resolution,
  input wire [15:0] ramp_time_primary,
  input wire [15:0] ramp_time_secondary,
  input wire [15:0] changeover_freq,
  input wire ramp_step_sel_low,
  input wire ramp_step_sel_mid,
  input wire ramp_step_sel_high,
  input wire [15:0] ramp_step_time,
  input wire [15:0] speed_loop_prop_gain,
  input wire [15:0] speed_loop_integral_gain,
  input wire speed_loop_gain_load,
  output reg [15:0] command_freq_r,
  output reg signed [17:0] regulator_out_r,
  output reg manual_mode_r,
  output reg sample_tick_r,
  output reg [31:0] ramp_span_r,
  output reg [15:0] speed_loop_kp_r,
  output reg [15:0] speed_loop_ki_r
);

////////////////////////////////////////////////////////////////////////
// Helpers

// Multiply a signed value by a percentage in 0.1 % steps
function signed [33:0] pct_mul;
  input signed [33:0] val;
  input [15:0] pct;
  reg signed [51:0] prod;
  begin
    prod = val * $signed({1'b0, pct});
    // A part-select is unsigned; re-sign it so negative values divide
    pct_mul = $signed(prod[33:0]) / $signed({18'h00000, `PCT_FULL});
  end
endfunction

// Saturate a wide signed value into 18 bits
function signed [17:0] sat18;
  input signed [33:0] val;
  begin
    if (val > 34'sh0001ffff) begin
      sat18 = 18'sh1ffff;
    end else if (val < -34'sh00020000) begin
      sat18 = -18'sh20000;
    end else begin
      sat18 = val[17:0];
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////
// Sample period divider

reg [31:0] tick_cnt_r; // Cycles into the current sample
wire tick = (tick_cnt_r == SAMPLE_CYCLES - 1);

// Free-running divider producing one enable per control sample
always @(posedge core_clk) begin
  if (sys_rst) begin
    tick_cnt_r <= 32'h00000000;
  end else if (tick) begin
    tick_cnt_r <= 32'h00000000;
  end else begin
    tick_cnt_r <= tick_cnt_r + 32'h00000001;
  end
end

////////////////////////////////////////////////////////////////////////
// Error and terms

reg [15:0] feedback; // Selected feedback sample
// Feedback source mux; unused code falls back to the current input
always @* begin
  case (feedback_select)
    `FB_VMAIN: feedback = voltage_input_main;
    `FB_VEXP: feedback = voltage_input_expansion;
    default: feedback = current_input;
  endcase
end

wire signed [17:0] error = $signed({2'h0, set_point})
  - $signed({2'h0, feedback});
reg signed [17:0] prev_error_r; // Error of the previous sample
reg signed [33:0] integ_r; // Integral sum, scaled by samples per step
reg signed [33:0] total_r; // Combined terms after each sample

// Bypass swaps in the secondary gain; both share one scale
wire [15:0] gain_sel = manual_bypass_input ? secondary_prop_gain
  : prop_gain;
wire signed [33:0] gain_eff = pct_mul({18'h00000, gain_sel},
  prop_gain_scale);
wire signed [33:0] p_term = pct_mul({{16{error[17]}}, error},
  gain_eff[15:0]);
// Integral contributes sum / (time * samples per tenth); time 0 off
wire [31:0] i_div = integral_time * `SAMPLES_PER_TENTH;
wire signed [33:0] i_term = (integral_time == 16'h0000) ? 34'sh0
  : integ_r / $signed({2'h0, i_div});
wire signed [17:0] d_err = error - prev_error_r;
// Derivative time in 0.1 ms units against a 1 ms sample
wire signed [33:0] d_term = ($signed({{16{d_err[17]}}, d_err})
  * $signed({18'h00000, derivative_time})) / 34'sd10;
wire signed [33:0] ff_term = pct_mul({18'h00000, set_point},
  feed_forward_gain);

// Integrator and error history, updated once per sample
always @(posedge core_clk) begin
  if (sys_rst) begin
    integ_r <= 34'sh0;
    prev_error_r <= 18'sh0;
    total_r <= 34'sh0;
  end else begin
    if (integrator_clear_input) begin
      integ_r <= 34'sh0;
    end else if (tick && regulation_enable && !manual_bypass_input) begin
      integ_r <= integ_r + {{16{error[17]}}, error};
    end
    if (tick) begin
      prev_error_r <= error;
      // D is summed with the P, I and feed-forward terms into one total
      total_r <= p_term + i_term + d_term + ff_term;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Output shaping and command frequency

wire signed [33:0] inv_val = output_negate_option ? -total_r
  : total_r;
wire signed [33:0] scaled = pct_mul(inv_val, output_scale_factor);
// Full scale of error maps to max frequency
wire signed [51:0] as_freq = (scaled * $signed({18'h0, max_freq}))
  / $signed({36'h0, `FS_VAL});
wire signed [17:0] reg_val = manual_bypass_input ? 18'sh0
  : sat18(as_freq[33:0]);
wire signed [18:0] sum = $signed({3'h0, target_freq})
  + {reg_val[17], reg_val};
reg [15:0] clamped; // Command frequency after limits

// Limits apply only while regulation is running; negative sums floor
always @* begin
  if (!regulation_enable || manual_bypass_input) begin
    clamped = target_freq;
  end else if (sum > $signed({3'h0, output_freq_upper_limit})) begin
    clamped = output_freq_upper_limit;
  end else if (sum < $signed({3'h0, output_freq_lower_limit})) begin
    clamped = output_freq_lower_limit;
  end else begin
    clamped = sum[15:0];
  end
end

// Registered outputs; regulator and command refreshed at each sample, or every cycle in bypass
always @(posedge core_clk) begin
  if (sys_rst) begin
    command_freq_r <= `FREQ_0HZ;
    regulator_out_r <= 18'sh0;
    manual_mode_r <= 1'b0;
    sample_tick_r <= 1'b0;
  end else begin
    sample_tick_r <= tick;
    manual_mode_r <= manual_bypass_input;
    if (tick || manual_bypass_input) begin
      regulator_out_r <= reg_val;
      command_freq_r <= clamped;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Ramp selection: span in 10 ms steps for the active ramp

wire step_sel = ramp_step_sel_low | ramp_step_sel_mid
  | ramp_step_sel_high;
// Change-over frequency: below it the primary ramp, above the secondary
wire [15:0] ramp_raw = step_sel ? ramp_step_time
  : (present_freq < changeover_freq) ? ramp_time_primary
  : ramp_time_secondary;
reg [31:0] ramp_ticks; // Ramp time in 10 ms units
// Resolution code scales the setting to a common base
always @* begin
  case (ramp_resolution)
    `RES_100MS: ramp_ticks = {16'h0, ramp_raw} * 32'd10;
    `RES_1S: ramp_ticks = {16'h0, ramp_raw} * 32'd100;
    default: ramp_ticks = {16'h0, ramp_raw};
  endcase
end
wire [15:0] delta_f = (target_freq > present_freq)
  ? target_freq - present_freq : present_freq - target_freq;
// Mode 0: time refers to full span; scale by the fraction of max used
wire [47:0] span_max = (max_freq == 16'h0000) ? 48'h0
  : ({16'h0, ramp_ticks} * {32'h0, delta_f}) / {32'h0, max_freq};

// Ramp span register and speed loop gains
always @(posedge core_clk) begin
  if (sys_rst) begin
    ramp_span_r <= 32'h00000000;
    speed_loop_kp_r <= SL_PGAIN_DEFAULT;
    speed_loop_ki_r <= SL_IGAIN_DEFAULT;
  end else begin
    if (ramp_ref_mode == `RAMP_REF_DELTA) begin
      ramp_span_r <= ramp_ticks;
    end else begin
      ramp_span_r <= span_max[31:0];
    end
    if (speed_loop_gain_load) begin
      speed_loop_kp_r <= speed_loop_prop_gain;
      speed_loop_ki_r <= speed_loop_integral_gain;
    end
  end
end

endmodule

// [verif/analog_sensor.sv]
// Model of the analog feedback sensors wired to the regulator.
// Assumes samples change just after a core_clk edge.
`timescale 1ns/1ns
module analog_sensor (
  input wire core_clk,
  input wire [15:0] fb_level,
  input wire [1:0] fb_chan,
  output logic [15:0] current_input,
  output logic [15:0] voltage_input_main,
  output logic [15:0] voltage_input_expansion
);
  // Unselected inputs read full scale, so a wrong source shows no error
  always @(posedge core_clk) begin
    current_input <= (fb_chan == 2'h0) ? fb_level : 16'h4000;
    voltage_input_main <= (fb_chan == 2'h1) ? fb_level : 16'h4000;
    voltage_input_expansion <= (fb_chan == 2'h2) ? fb_level : 16'h4000;
  end
endmodule

// [verif/pid_regulator_assertions.sv]
// Port-level checks on the regulator.
// Assumes one core_clk domain and sys_rst active high.
`timescale 1ns/1ns
module pid_checker #(
  parameter int SAMPLE_CYCLES = 20,
  parameter [15:0] SL_PGAIN_DEFAULT = 16'h03e8,
  parameter [15:0] SL_IGAIN_DEFAULT = 16'h0064
) (
  input wire core_clk,
  input wire sys_rst,
  input wire regulation_enable,
  input wire manual_bypass_input,
  input wire [15:0] output_freq_upper_limit,
  input wire [15:0] command_freq_r,
  input wire signed [17:0] regulator_out_r,
  input wire manual_mode_r,
  input wire sample_tick_r,
  input wire [31:0] ramp_span_r,
  input wire ramp_ref_mode,
  input wire [1:0] ramp_resolution,
  input wire ramp_step_sel_low,
  input wire ramp_step_sel_mid,
  input wire ramp_step_sel_high,
  input wire [15:0] ramp_step_time,
  input wire [15:0] speed_loop_prop_gain,
  input wire [15:0] speed_loop_integral_gain,
  input wire speed_loop_gain_load,
  input wire [15:0] speed_loop_kp_r,
  input wire [15:0] speed_loop_ki_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Any step select line overrides the change-over ramps
  wire step_any = ramp_step_sel_low | ramp_step_sel_mid | ramp_step_sel_high;
  // Cycles since the last sample tick; counted instead of a long delay
  logic [31:0] gap_r;
  logic seen_r;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      gap_r <= 32'h0;
      seen_r <= 1'b0;
    end else if (sample_tick_r) begin
      gap_r <= 32'h1;
      seen_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 32'h1;
    end
  end
  a_tick_period: assert property (seen_r |->
    (sample_tick_r == (gap_r == SAMPLE_CYCLES)))
    else $error("sample tick spacing");
  a_sl_defaults: assert property ($fell(sys_rst) |->
    speed_loop_kp_r == SL_PGAIN_DEFAULT && speed_loop_ki_r == SL_IGAIN_DEFAULT)
    else $error("speed gain reset value");
  a_kp_load: assert property (speed_loop_gain_load |=>
    speed_loop_kp_r == $past(speed_loop_prop_gain)) else $error("kp load");
  a_ki_load: assert property (speed_loop_gain_load |=>
    speed_loop_ki_r == $past(speed_loop_integral_gain)) else $error("ki load");
  a_bypass_zero: assert property (manual_bypass_input [*3] |->
    regulator_out_r == 18'sh0 && manual_mode_r) else $error("bypass output");
  // Limit and mode held across the sample so the clamp is well defined
  a_upper_clamp: assert property (sample_tick_r && regulation_enable
    && $past(regulation_enable) && !$past(manual_bypass_input)
    && output_freq_upper_limit == $past(output_freq_upper_limit)
    ##1 !manual_bypass_input |->
    command_freq_r <= $past(output_freq_upper_limit)) else $error("clamp");
  a_step_prio: assert property (step_any && ramp_ref_mode
    && ramp_resolution == 2'h0 |=> ramp_span_r == {16'h0,
    $past(ramp_step_time)}) else $error("step ramp span");
  a_res_scale: assert property (step_any && ramp_ref_mode
    && ramp_resolution == 2'h2 |=> ramp_span_r == {16'h0,
    $past(ramp_step_time)} * 32'h64) else $error("ramp resolution");
endmodule
bind pid_regulator pid_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES),
  .SL_PGAIN_DEFAULT(SL_PGAIN_DEFAULT),
  .SL_IGAIN_DEFAULT(SL_IGAIN_DEFAULT)) u_chk (.*);

// [verif/testbench.sv]
// Directed bench for the regulator with a sensor model on the inputs.
// Assumes a short sample period set through SAMPLE_CYCLES.
`timescale 1ns/1ns
module testbench;
  logic core_clk = 0, sys_rst = 1, regulation_enable = 0;
  logic output_negate_option = 0, manual_bypass_input = 0;
  logic integrator_clear_input = 0, ramp_ref_mode = 0;
  logic speed_loop_gain_load = 0, ramp_step_sel_low = 0;
  logic ramp_step_sel_mid = 0, ramp_step_sel_high = 0;
  logic [1:0] feedback_select = 0, ramp_resolution = 0, fb_chan = 0;
  logic [15:0] set_point = 16'h4000, fb_level = 16'h0000;
  logic [15:0] prop_gain = 16'h03e8, secondary_prop_gain = 16'h01f4;
  logic [15:0] prop_gain_scale = 16'h03e8, integral_time = 16'h0000;
  logic [15:0] derivative_time = 16'h0000, feed_forward_gain = 16'h0000;
  logic [15:0] output_scale_factor = 16'h03e8, target_freq = 16'h2000;
  logic [15:0] output_freq_upper_limit = 16'h7000, max_freq = 16'h1000;
  logic [15:0] output_freq_lower_limit = 16'h0000, present_freq = 16'h0080;
  logic [15:0] ramp_time_primary = 16'h0007, changeover_freq = 16'h0100;
  logic [15:0] ramp_time_secondary = 16'h0009, ramp_step_time = 16'h0005;
  logic [15:0] speed_loop_prop_gain = 16'h0123;
  logic [15:0] speed_loop_integral_gain = 16'h0045;
  logic [31:0] span_tab [3] = '{32'h5, 32'h32, 32'h1f4};
  wire [15:0] current_input, voltage_input_main, voltage_input_expansion;
  wire [15:0] command_freq_r, speed_loop_kp_r, speed_loop_ki_r;
  wire signed [17:0] regulator_out_r;
  wire manual_mode_r, sample_tick_r;
  wire [31:0] ramp_span_r;
  int err_count = 0, total_checks = 0, cyc = 0, i;
  // Short sample period keeps each settle to a few dozen cycles
  pid_regulator #(.SAMPLE_CYCLES(20)) DUT (.*);
  analog_sensor u_fb (.*);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Three ticks cover the two-sample latency from input to output
  task pid(input logic [31:0] r_exp, input logic [31:0] c_exp);
    int n;
    n = 0;
    while (n < 3) begin
      @(negedge core_clk);
      if (sample_tick_r === 1'b1) n++;
    end
    repeat (2) @(negedge core_clk);
    chk({14'h0, regulator_out_r}, r_exp);
    chk({16'h0, command_freq_r}, c_exp);
  endtask
  task span(input logic [31:0] exp);
    repeat (2) @(negedge core_clk);
    chk(ramp_span_r, exp);
  endtask
  task summarize;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial forever #10 core_clk = ~core_clk;
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(negedge core_clk);
    sys_rst = 0;
    chk({16'h0, speed_loop_kp_r}, 32'h3e8);
    chk({16'h0, speed_loop_ki_r}, 32'h64);
    regulation_enable = 1;
    pid(32'h1000, 32'h3000);
    prop_gain = 16'h01f4;
    pid(32'h0800, 32'h2800);
    prop_gain = 16'h03e8;
    prop_gain_scale = 16'h01f4;
    pid(32'h0800, 32'h2800);
    prop_gain_scale = 16'h03e8;
    output_scale_factor = 16'h01f4;
    pid(32'h0800, 32'h2800);
    output_scale_factor = 16'h03e8;
    output_freq_upper_limit = 16'h2800;
    pid(32'h1000, 32'h2800);
    output_negate_option = 1;
    output_freq_lower_limit = 16'h1800;
    pid(32'h3f000, 32'h1800);
    output_negate_option = 0;
    output_freq_upper_limit = 16'h7000;
    fb_level = 16'h2000;
    for (i = 0; i < 3; i++) begin
      fb_chan = i[1:0];
      feedback_select = i[1:0];
      pid(32'h0800, 32'h2800);
    end
    fb_level = 16'h4000;
    feed_forward_gain = 16'h03e8;
    pid(32'h1000, 32'h3000);
    feed_forward_gain = 16'h0000;
    fb_level = 16'h0000;
    manual_bypass_input = 1;
    integrator_clear_input = 1;
    pid(32'h0, 32'h2000);
    chk({31'h0, manual_mode_r}, 32'h1);
    manual_bypass_input = 0;
    // Clear held with integral on: the sum must stay at zero
    integral_time = 16'h0001;
    pid(32'h1000, 32'h3000);
    // Integral only: full scale over 100 samples, one sample seen
    prop_gain = 16'h0000;
    integrator_clear_input = 0;
    pid(32'h28, 32'h2028);
    integral_time = 16'h0000;
    prop_gain = 16'h03e8;
    ramp_ref_mode = 1;
    for (i = 0; i < 3; i++) begin
      {ramp_step_sel_high, ramp_step_sel_mid, ramp_step_sel_low} = 3'h1 << i;
      ramp_resolution = i[1:0];
      span(span_tab[i]);
    end
    {ramp_step_sel_high, ramp_step_sel_mid, ramp_step_sel_low} = 3'h0;
    ramp_resolution = 2'h0;
    span(32'h7);
    present_freq = 16'h0100;
    span(32'h9);
    // Full-span mode: 90 ticks times half of max frequency
    ramp_ref_mode = 0;
    ramp_resolution = 2'h1;
    target_freq = 16'h0900;
    span(32'h2d);
    speed_loop_gain_load = 1;
    @(negedge core_clk);
    speed_loop_gain_load = 0;
    @(negedge core_clk);
    chk({16'h0, speed_loop_kp_r}, 32'h123);
    chk({16'h0, speed_loop_ki_r}, 32'h45);
    summarize();
  end
endmodule
